// >>> hw/amrp_top.sv
// Top of the address-map, reset and protection block.
// Assumes a classic Wishbone master and a core on the same clock.
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module amrp_top #(
  parameter int POR_CYCLES = amrp_pkg::POR_CYCLES,  // Power-on timeout
  parameter int GP_REGS    = amrp_pkg::GP_REGS_DEF  // 236 or 125
) (
  input  wire logic         clock,        // 40 MHz system clock
  input  wire logic         reset,        // Synchronous power-up reset
  input  wire logic         wb_cyc,       // Bus cycle
  input  wire logic         wb_stb,       // Bus strobe
  input  wire logic         wb_we,        // Bus write
  input  wire logic [7:0]   wb_adr,       // Byte address
  input  wire logic [3:0]   wb_sel,       // Byte lanes
  input  wire logic [31:0]  wb_dat_w,     // Write data
  output logic [31:0]       wb_dat_r,     // Read data
  output logic              wb_ack,       // Bus acknowledge
  input  wire logic         romless_pin,  // ROMless strap
  input  wire logic         wdt_timeout,  // Watchdog expiry pulse
  input  wire logic         stop_mode,    // Core is stopped
  input  wire logic [7:0]   stop_wake,    // Wake source lines
  output logic              core_reset,   // Core reset
  output logic              pc_load,      // Load program counter
  output logic [15:0]       pc_load_addr, // Reset address
  input  wire logic         fetch_req,    // Fetch strobe
  input  wire logic         fetch_first,  // Fetch starts an instruction
  input  wire logic [15:0]  fetch_addr,   // Fetch address
  output logic              fetch_int,    // Fetch internal
  output logic              fetch_vec,    // Fetch in vectors
  output logic              fetch_user,   // Fetch in user area
  input  wire logic         load_req,     // Code load strobe
  input  wire logic [1:0]   load_kind,    // Which code load
  input  wire logic [15:0]  load_addr,    // Code load address
  input  wire logic [7:0]   pm_rdata,     // Program memory data
  output logic [7:0]        load_data,    // Load result
  output logic              load_blocked, // Load was refused
  input  wire logic         ra_req,       // Register address strobe
  input  wire amrp_pkg::amrp_amode_t ra_mode, // Addressing mode
  input  wire logic [7:0]   ra_operand,   // Address field
  output logic [7:0]        ra_addr,      // Resolved address
  output logic              ra_ok,        // Address reaches a register
  output amrp_pkg::amrp_rclass_t ra_class, // Register kind
  output logic [3:0]        erf_bank,     // Expanded bank
  output logic [7:0]        wdtm_out,     // Watchdog mode
  output logic [7:0]        p2m_out,      // Port 2 mode
  output logic [7:0]        p3m_out       // Port 3 mode
);
  amrp_rst_if rif ();

  logic [7:0]  rp_r, ctrl_r, wdtm_r, smr_r, p2m_r, p3m_r;
  logic [2:0]  cause_r;
  logic        romless_r, exec_ext_r, ack_r;
  logic [31:0] dat_r;
  logic        m_fint, m_fvec, m_fuser, m_lint, m_block;
  logic        f_int_r, f_vec_r, f_user_r, l_blk_r;
  logic [7:0]  l_dat_r, ra_addr_r;
  logic        ra_ok_r;
  logic [3:0]  bank_r;
  amrp_pkg::amrp_rclass_t ra_class_r;
  logic        wr, rd;
  logic [7:0]  wbyte, ra_nxt;
  logic        ok_nxt;

  // ==========================================================
  // Reset sources
  amrp_reset_gen #(.POR_CYCLES(POR_CYCLES)) u_rst (
    .clock (clock),
    .reset (reset),
    .rif   (rif)
  );

  // Watchdog and armed stop wake source request reset
  assign rif.wdt_req  = wdt_timeout;
  assign rif.stop_req = stop_mode
    && (stop_wake[smr_r[amrp_pkg::SMR_SRC_LSB +: 3]]
        == smr_r[amrp_pkg::SMR_POL_BIT]);

  // ROMless strap caught while reset is applied
  always_ff @(posedge clock) begin
    if (reset) begin
      romless_r <= romless_pin;
    end
  end

  // Last reset cause: bit 0 power-on, 1 watchdog, 2 stop
  always_ff @(posedge clock) begin
    if (reset) begin
      cause_r <= 3'h1;
    end else if (rif.wdt_take) begin
      cause_r <= 3'h2;
    end else if (rif.stop_take) begin
      cause_r <= 3'h4;
    end
  end

  // ==========================================================
  // Wishbone slave
  assign wr    = wb_cyc && wb_stb && wb_we && !ack_r && wb_sel[0];
  assign rd    = wb_cyc && wb_stb && !wb_we && !ack_r;
  assign wbyte = wb_dat_w[7:0];

  // One-cycle acknowledge, any address answers
  always_ff @(posedge clock) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc && wb_stb && !ack_r;
    end
  end

  // Read data, unmapped and write-only read zero
  always_ff @(posedge clock) begin
    if (reset) begin
      dat_r <= 32'h0;
    end else if (rd) begin
      case (wb_adr)
        amrp_pkg::ADR_RP:   dat_r <= {24'h0, rp_r};
        amrp_pkg::ADR_CTRL: dat_r <= {24'h0, ctrl_r};
        amrp_pkg::ADR_STAT: dat_r <= {27'h0, rif.core_reset, romless_r, cause_r};
        amrp_pkg::ADR_SMR:  dat_r <= {24'h0, smr_r[7], 7'h0};
        amrp_pkg::ADR_P2M:  dat_r <= {24'h0, p2m_r};
        amrp_pkg::ADR_P3M:  dat_r <= {24'h0, p3m_r};
        default:            dat_r <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Register pointer and control
  // Pointer clears on every reset source
  always_ff @(posedge clock) begin
    if (reset || rif.wdt_take || rif.stop_take) begin
      rp_r <= amrp_pkg::RP_RST;
    end else if (wr && wb_adr == amrp_pkg::ADR_RP) begin
      rp_r <= wbyte;
    end
  end

  // Protection enable
  always_ff @(posedge clock) begin
    if (reset || rif.wdt_take || rif.stop_take) begin
      ctrl_r <= amrp_pkg::CTRL_RST;
    end else if (wr && wb_adr == amrp_pkg::ADR_CTRL) begin
      ctrl_r <= wbyte;
    end
  end

  // ==========================================================
  // Mode registers kept through stop recovery
  always_ff @(posedge clock) begin
    if (reset || rif.wdt_take) begin
      wdtm_r <= amrp_pkg::WDTM_RST;
      p2m_r  <= amrp_pkg::P2M_RST;
      p3m_r  <= amrp_pkg::P3M_RST;
    end else if (wr) begin
      if (wb_adr == amrp_pkg::ADR_WDTM) begin
        wdtm_r <= wbyte;
      end
      if (wb_adr == amrp_pkg::ADR_P2M) begin
        p2m_r <= wbyte;
      end
      if (wb_adr == amrp_pkg::ADR_P3M) begin
        p3m_r <= wbyte;
      end
    end
  end

  // Stop recovery fields; flag set by recovery, cleared by power-on only
  always_ff @(posedge clock) begin
    if (reset) begin
      smr_r <= amrp_pkg::SMR_RST;
    end else begin
      if (rif.wdt_take) begin
        smr_r[6:0] <= amrp_pkg::SMR_RST[6:0];
      end else if (wr && wb_adr == amrp_pkg::ADR_SMR) begin
        smr_r[6:0] <= wbyte[6:0];
      end
      if (rif.stop_take) begin
        smr_r[amrp_pkg::SMR_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Program memory map and protection
  amrp_mem_map u_map (
    .romless    (romless_r),
    .protect    (ctrl_r[amrp_pkg::CTRL_PROT_BIT]),
    .exec_ext   (exec_ext_r),
    .fetch_addr (fetch_addr),
    .load_addr  (load_addr),
    .fetch_int  (m_fint),
    .fetch_vec  (m_fvec),
    .fetch_user (m_fuser),
    .load_int   (m_lint),
    .load_block (m_block)
  );

  // Execution source follows each instruction's first fetch
  always_ff @(posedge clock) begin
    if (reset || rif.core_reset) begin
      exec_ext_r <= romless_r;
    end else if (fetch_req && fetch_first) begin
      exec_ext_r <= !m_fint;
    end
  end

  // Registered fetch decode
  always_ff @(posedge clock) begin
    if (reset) begin
      f_int_r  <= 1'b0;
      f_vec_r  <= 1'b0;
      f_user_r <= 1'b0;
    end else if (fetch_req) begin
      f_int_r  <= m_fint;
      f_vec_r  <= m_fvec;
      f_user_r <= m_fuser;
    end
  end

  // Load result; all four code load kinds share the rule
  always_ff @(posedge clock) begin
    if (reset) begin
      l_dat_r <= 8'h00;
      l_blk_r <= 1'b0;
    end else if (load_req) begin
      l_blk_r <= m_block;
      l_dat_r <= m_block ? amrp_pkg::BLOCKED_DATA : pm_rdata;
    end
  end

  // ==========================================================
  // Register file addressing
  // Resolve operand per mode
  always_comb begin
    ra_nxt = ra_operand;
    ok_nxt = 1'b1;
    case (ra_mode)
      amrp_pkg::AM_WORKING: ra_nxt = {rp_r[7:4], ra_operand[3:0]};
      amrp_pkg::AM_INDIRECT: ok_nxt = 1'b1;
      amrp_pkg::AM_DIRECT: begin
        ok_nxt = !amrp_pkg::amrp_in_span({8'h00, ra_operand},
                                         {8'h00, amrp_pkg::WBANK_BASE},
                                         {8'h00, amrp_pkg::WBANK_TOP});
      end
      default: ok_nxt = 1'b0;
    endcase
  end

  // Register kind of a resolved address
  function automatic amrp_pkg::amrp_rclass_t rclass(input logic [7:0] a);
    if (a < 8'(amrp_pkg::GP_BASE - 8'h01)) begin
      return amrp_pkg::RC_PORT;
    end else if (a >= amrp_pkg::GP_BASE && a < 8'(amrp_pkg::GP_BASE + 8'(GP_REGS))) begin
      return amrp_pkg::RC_GP;
    end else if (a >= amrp_pkg::CTRL_BASE) begin
      return amrp_pkg::RC_CTRL;
    end
    return amrp_pkg::RC_NONE;
  endfunction

  // Registered address result
  always_ff @(posedge clock) begin
    if (reset) begin
      ra_addr_r  <= 8'h00;
      ra_ok_r    <= 1'b0;
      ra_class_r <= amrp_pkg::RC_NONE;
      bank_r     <= 4'h0;
    end else if (ra_req) begin
      ra_addr_r  <= ra_nxt;
      ra_ok_r    <= ok_nxt && (rclass(ra_nxt) != amrp_pkg::RC_NONE);
      ra_class_r <= rclass(ra_nxt);
      bank_r     <= rp_r[3:0];
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack       = ack_r;
  assign wb_dat_r     = dat_r;
  assign core_reset   = rif.core_reset;
  assign pc_load      = rif.pc_load;
  assign pc_load_addr = amrp_pkg::PC_RESET;
  assign fetch_int    = f_int_r;
  assign fetch_vec    = f_vec_r;
  assign fetch_user   = f_user_r;
  assign load_data    = l_dat_r;
  assign load_blocked = l_blk_r;
  assign ra_addr      = ra_addr_r;
  assign ra_ok        = ra_ok_r;
  assign ra_class     = ra_class_r;
  assign erf_bank     = bank_r;
  assign wdtm_out     = wdtm_r;
  assign p2m_out      = p2m_r;
  assign p3m_out      = p3m_r;

  // ==========================================================
  // Checks
  a_rp_cleared: assert property (@(posedge clock) disable iff (reset)
    (rif.wdt_take || rif.stop_take) |=> rp_r == 8'h00)
    else $error("pointer not cleared by reset");
  a_stop_keeps: assert property (@(posedge clock) disable iff (reset)
    rif.stop_take |=> (wdtm_r == $past(wdtm_r)) && (p3m_r == $past(p3m_r)))
    else $error("mode register lost on stop recovery");
  a_block_value: assert property (@(posedge clock) disable iff (reset)
    (load_req && ctrl_r[0] && exec_ext_r && !romless_r && load_addr <= 16'h0FFF)
    |=> load_blocked && load_data == 8'hFF)
    else $error("protected load not blocked");
  a_internal_ok: assert property (@(posedge clock) disable iff (reset)
    (load_req && !exec_ext_r) |=> !load_blocked && load_data == $past(pm_rdata))
    else $error("internal load refused");
  a_work_group: assert property (@(posedge clock) disable iff (reset)
    (ra_req && ra_mode == amrp_pkg::AM_WORKING)
    |=> ra_addr == {$past(rp_r[7:4]), $past(ra_operand[3:0])})
    else $error("working register address wrong");
  a_direct_bank: assert property (@(posedge clock) disable iff (reset)
    (ra_req && ra_mode == amrp_pkg::AM_DIRECT && ra_operand[7:4] == 4'hE)
    |=> !ra_ok)
    else $error("direct access reached bank E");
  a_vec_area: assert property (@(posedge clock) disable iff (reset)
    (fetch_req && !romless_r && fetch_addr < 16'h000C) |=> fetch_vec && !fetch_user)
    else $error("vector area decode wrong");
  a_ack_pulse: assert property (@(posedge clock) disable iff (reset)
    wb_ack |=> !wb_ack)
    else $error("acknowledge held too long");
endmodule
`default_nettype wire

// >>> hw/amrp_pkg.sv
// Constants, types and helpers shared by the address-map block.
// Assumes one 40 MHz clock and a synchronous active-high reset.
package amrp_pkg;
  // ==========================================================
  // Bus register offsets and fields
  localparam logic [7:0] ADR_RP   = 8'h00;
  localparam logic [7:0] ADR_CTRL = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_WDTM = 8'h0C;
  localparam logic [7:0] ADR_SMR  = 8'h10;
  localparam logic [7:0] ADR_P2M  = 8'h14;
  localparam logic [7:0] ADR_P3M  = 8'h18;
  localparam int CTRL_PROT_BIT = 0;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_RL_BIT   = 3;
  localparam int SMR_FLAG_BIT  = 7;
  localparam int SMR_POL_BIT   = 6;
  localparam int SMR_SRC_LSB   = 2;
  localparam logic [7:0] RP_RST   = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] WDTM_RST = 8'h00;
  localparam logic [7:0] SMR_RST  = 8'h00;
  localparam logic [7:0] P2M_RST  = 8'h00;
  localparam logic [7:0] P3M_RST  = 8'h00;
  localparam logic [7:0] BLOCKED_DATA = 8'hFF;
  // ==========================================================
  // Program memory map
  localparam logic [15:0] VEC_BASE    = 16'h0000;
  localparam logic [15:0] USER_START  = 16'h000C;
  localparam logic [15:0] INT_PM_TOP  = 16'h0FFF;
  localparam logic [15:0] PC_RESET    = 16'h000C;
  // ==========================================================
  // Register file map
  localparam logic [7:0] GP_BASE    = 8'h04;
  localparam logic [7:0] WBANK_BASE = 8'hE0;
  localparam logic [7:0] WBANK_TOP  = 8'hEF;
  localparam logic [7:0] CTRL_BASE  = 8'hF1;
  localparam logic [7:0] CTRL_TOP   = 8'hFF;
  localparam int GP_REGS_DEF = 236;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ      = 40;
  localparam int POR_TIME_US  = 5000;
  localparam int POR_CYCLES   = POR_TIME_US * CLK_MHZ;
  localparam int HOLD_TIME_NS = 100;
  localparam int HOLD_CYCLES  = (HOLD_TIME_NS * CLK_MHZ + 999) / 1000;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {AM_DIRECT, AM_INDIRECT, AM_WORKING} amrp_amode_t;
  typedef enum logic [1:0] {RC_PORT, RC_GP, RC_CTRL, RC_NONE} amrp_rclass_t;

  // Inclusive range test on 16-bit addresses
  function automatic logic amrp_in_span(input logic [15:0] a,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

// >>> hw/amrp_rst_if.sv
// Reset handshake between the reset sequencer and the block top.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface amrp_rst_if;
  logic wdt_req;    // Watchdog timeout seen
  logic stop_req;   // Armed stop wake source active
  logic core_reset; // Core held in reset
  logic pc_load;    // Load reset address
  logic wdt_take;   // Watchdog reset accepted
  logic stop_take;  // Stop recovery reset accepted
  modport gen (input wdt_req, stop_req,
               output core_reset, pc_load, wdt_take, stop_take);
  modport use_ (output wdt_req, stop_req,
                input core_reset, pc_load, wdt_take, stop_take);
endinterface
`default_nettype wire

// >>> hw/amrp_reset_gen.sv
// Reset sequencer: power-on timeout, then watchdog and stop resets.
// Assumes requests are synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module amrp_reset_gen #(
  parameter int POR_CYCLES = amrp_pkg::POR_CYCLES
) (
  input  wire logic clock, // System clock
  input  wire logic reset, // Synchronous power-up reset
  amrp_rst_if.gen   rif    // Reset handshake
);
  localparam int CW = $clog2(POR_CYCLES + 1);
  typedef enum logic [1:0] {RG_POR, RG_HOLD, RG_RUN} amrp_rg_state_t;
  amrp_rg_state_t state_r;
  logic [CW-1:0]  cnt_r;
  logic           pc_load_r;
  logic           leave;

  // ==========================================================
  // Sequencer
  // End of a timeout
  always_comb begin
    case (state_r)
      RG_POR:  leave = (cnt_r == CW'(POR_CYCLES - 1));
      RG_HOLD: leave = (cnt_r == CW'(amrp_pkg::HOLD_CYCLES - 1));
      default: leave = 1'b0;
    endcase
  end

  // State and counter
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= RG_POR;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        RG_POR, RG_HOLD: begin
          cnt_r <= leave ? '0 : cnt_r + 1'b1;
          if (leave) begin
            state_r <= RG_RUN;
          end
        end
        RG_RUN: begin
          if (rif.wdt_req || rif.stop_req) begin
            state_r <= RG_HOLD;
          end
        end
        default: state_r <= RG_POR;
      endcase
    end
  end

  // Reset address load on release
  always_ff @(posedge clock) begin
    if (reset) begin
      pc_load_r <= 1'b0;
    end else begin
      pc_load_r <= leave;
    end
  end

  assign rif.core_reset = (state_r != RG_RUN);
  assign rif.pc_load    = pc_load_r;
  assign rif.wdt_take   = (state_r == RG_RUN) && rif.wdt_req;
  assign rif.stop_take  = (state_r == RG_RUN) && rif.stop_req && !rif.wdt_req;

  // ==========================================================
  // Checks
  a_hold_len: assert property (@(posedge clock) disable iff (reset)
    $rose(rif.core_reset) |-> rif.core_reset[*4] ##1 !rif.core_reset)
    else $error("hold reset length wrong");
  a_take_reset: assert property (@(posedge clock) disable iff (reset)
    (rif.wdt_take || rif.stop_take) |=> rif.core_reset)
    else $error("accepted reset not applied");
  a_pc_release: assert property (@(posedge clock) disable iff (reset)
    $fell(rif.core_reset) |-> rif.pc_load ##1 !rif.pc_load)
    else $error("reset address load missing");
endmodule
`default_nettype wire

// >>> hw/amrp_mem_map.sv
// Program memory map decode and load protection check.
// Assumes addresses are stable while their request is high.
`timescale 1ns/1ps
`default_nettype none
module amrp_mem_map (
  input  wire logic        romless,    // External program memory only
  input  wire logic        protect,    // Load protection on
  input  wire logic        exec_ext,   // Running from external memory
  input  wire logic [15:0] fetch_addr, // Fetch address
  input  wire logic [15:0] load_addr,  // Code load address
  output logic             fetch_int,  // Fetch hits internal array
  output logic             fetch_vec,  // Fetch in vector table
  output logic             fetch_user, // Fetch in user area
  output logic             load_int,   // Load hits internal array
  output logic             load_block  // Load must be refused
);
  // Internal array only without ROMless, 4 KB deep
  assign fetch_int = !romless
    && amrp_pkg::amrp_in_span(fetch_addr, amrp_pkg::VEC_BASE,
                              amrp_pkg::INT_PM_TOP);
  assign fetch_vec = fetch_int
    && (fetch_addr < amrp_pkg::USER_START);
  assign fetch_user = fetch_int
    && amrp_pkg::amrp_in_span(fetch_addr, amrp_pkg::USER_START,
                              amrp_pkg::INT_PM_TOP);
  assign load_int = !romless
    && amrp_pkg::amrp_in_span(load_addr, amrp_pkg::VEC_BASE,
                              amrp_pkg::INT_PM_TOP);
  // Refuse only external code reading the internal array
  assign load_block = protect && exec_ext && load_int;
endmodule
`default_nettype wire

// >>> testbench/amrp_core_model.sv
// Core-side model: issues fetches and code loads, serves program bytes.
// Assumes the block samples requests on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module amrp_core_model (
  input  wire logic  clock,       // System clock
  output logic       fetch_req,   // Fetch strobe
  output logic       fetch_first, // Instruction start
  output logic [15:0] fetch_addr, // Fetch address
  output logic       load_req,    // Code load strobe
  output logic [1:0] load_kind,   // Load variant
  output logic [15:0] load_addr,  // Load address
  output logic [7:0] pm_rdata     // Program byte
);
  // ==========================================================
  // Program bytes follow the address
  assign pm_rdata = load_addr[7:0] ^ 8'hA5;
  // Idle values
  initial begin
    fetch_req = 1'b0;
    fetch_first = 1'b0;
    fetch_addr = 16'h0000;
    load_req = 1'b0;
    load_kind = 2'h0;
    load_addr = 16'h0000;
  end
  // One fetch; address changes once released
  task automatic fetch(input logic first, input logic [15:0] a);
    @(posedge clock);
    fetch_req <= 1'b1;
    fetch_first <= first;
    fetch_addr <= a;
    @(posedge clock);
    fetch_req <= 1'b0;
    fetch_addr <= ~a;
    @(posedge clock);
  endtask
  // One code load; address held so the byte stays put
  task automatic load(input logic [1:0] k, input logic [15:0] a);
    @(posedge clock);
    load_req <= 1'b1;
    load_kind <= k;
    load_addr <= a;
    @(posedge clock);
    load_req <= 1'b0;
    @(posedge clock);
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_mcu_address_map_reset_protect.sv
// Bench for the address-map block: bus, resets, map, protection.
// Assumes the core model drives fetch and load requests.
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_address_map_reset_protect;
  localparam int POR = 20;
  logic clock = 1'b0, reset = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00, ra_operand = 8'h00, stop_wake = 8'h00;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r, q;
  logic wb_ack, wdt_timeout = 1'b0, stop_mode = 1'b0, ra_req = 1'b0, romless = 1'b0;
  logic core_reset, pc_load, fetch_req, fetch_first, fetch_int, fetch_vec, fetch_user;
  logic load_req, load_blocked, ra_ok;
  logic [15:0] pc_load_addr, fetch_addr, load_addr;
  logic [1:0] load_kind;
  logic [7:0] pm_rdata, load_data, ra_addr, wdtm_out, p2m_out, p3m_out;
  logic [3:0] erf_bank;
  amrp_pkg::amrp_amode_t ra_mode = amrp_pkg::AM_DIRECT;
  amrp_pkg::amrp_rclass_t ra_class;
  int bad_count = 0, total_checks = 0, cyc = 0, n;
  // ==========================================================
  // Clock, design and core model
  always #12.5 clock = ~clock;
  amrp_top #(.POR_CYCLES(POR), .GP_REGS(236)) DUT (.clock(clock), .reset(reset),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'h1),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .romless_pin(romless),
    .wdt_timeout(wdt_timeout), .stop_mode(stop_mode), .stop_wake(stop_wake),
    .core_reset(core_reset), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
    .fetch_req(fetch_req), .fetch_first(fetch_first), .fetch_addr(fetch_addr),
    .fetch_int(fetch_int), .fetch_vec(fetch_vec), .fetch_user(fetch_user),
    .load_req(load_req), .load_kind(load_kind), .load_addr(load_addr),
    .pm_rdata(pm_rdata), .load_data(load_data), .load_blocked(load_blocked),
    .ra_req(ra_req), .ra_mode(ra_mode), .ra_operand(ra_operand), .ra_addr(ra_addr),
    .ra_ok(ra_ok), .ra_class(ra_class), .erf_bank(erf_bank), .wdtm_out(wdtm_out),
    .p2m_out(p2m_out), .p3m_out(p3m_out));
  amrp_core_model core (.clock(clock), .fetch_req(fetch_req), .fetch_first(fetch_first),
    .fetch_addr(fetch_addr), .load_req(load_req), .load_kind(load_kind),
    .load_addr(load_addr), .pm_rdata(pm_rdata));
  // Verdict and comparison
  task automatic give_verdict;
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict;
    end
  end
  // Classic single bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= {24'h0, d};
    do @(posedge clock); while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // Register address resolution
  task automatic ra(input amrp_pkg::amrp_amode_t m, input logic [7:0] op);
    @(posedge clock);
    ra_req <= 1'b1;
    ra_mode <= m;
    ra_operand <= op;
    @(posedge clock);
    ra_req <= 1'b0;
    @(posedge clock);
  endtask
  // Wait for a core reset, drop the cause, count its length
  task automatic rst_len;
    n = 0;
    while (core_reset !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    stop_mode <= 1'b0;
    wdt_timeout <= 1'b0;
    n = 0;
    while (core_reset === 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
  endtask
  // Power-on, pointer and map scenarios
  task automatic t_por_regs_map;
    logic [15:0] fa[5] = '{16'h0000, 16'h000B, 16'h000C, 16'h0FFF, 16'h1000};
    logic [2:0] fx[5] = '{3'b110, 3'b110, 3'b101, 3'b101, 3'b000};
    rst_len;
    chk(n, POR + 1);
    chk(pc_load, 1);
    chk(pc_load_addr, 16'h000C);
    wb(0, amrp_pkg::ADR_RP, 8'h00);
    chk(q, 0);
    wb(1, amrp_pkg::ADR_RP, 8'h5A);
    wb(0, 8'h1C, 8'h00);
    chk(q, 0);
    ra(amrp_pkg::AM_WORKING, 8'h03);
    chk({ra_addr, ra_ok, erf_bank, ra_class}, {8'h53, 1'b1, 4'hA, amrp_pkg::RC_GP});
    ra(amrp_pkg::AM_DIRECT, 8'h20);
    chk({ra_addr, ra_ok}, {8'h20, 1'b1});
    ra(amrp_pkg::AM_DIRECT, 8'hE5);
    chk(ra_ok, 0);
    ra(amrp_pkg::AM_INDIRECT, 8'hE5);
    chk(ra_ok, 1);
    ra(amrp_pkg::AM_DIRECT, 8'hF5);
    chk({ra_ok, ra_class}, {1'b1, amrp_pkg::RC_CTRL});
    ra(amrp_pkg::AM_DIRECT, 8'h02);
    chk({ra_ok, ra_class}, {1'b1, amrp_pkg::RC_PORT});
    for (int i = 0; i < 5; i++) begin
      core.fetch(1'b1, fa[i]);
      chk({fetch_int, fetch_vec, fetch_user}, fx[i]);
    end
  endtask
  // Protected loads from outside and inside, every variant
  task automatic t_protect;
    wb(1, amrp_pkg::ADR_CTRL, 8'h01);
    for (int k = 0; k < 4; k++) begin
      core.fetch(1'b1, 16'h2000);
      core.load(k[1:0], 16'h0100);
      chk({load_blocked, load_data}, {1'b1, 8'hFF});
      core.fetch(1'b1, 16'h0200);
      core.load(k[1:0], 16'h0100);
      chk({load_blocked, load_data}, {1'b0, 8'hA5});
    end
  endtask
  // Stop recovery keeps mode registers, watchdog does not
  task automatic t_recover;
    wb(1, amrp_pkg::ADR_P2M, 8'h33);
    wb(1, amrp_pkg::ADR_WDTM, 8'h5C);
    wb(1, amrp_pkg::ADR_P3M, 8'h21);
    wb(1, amrp_pkg::ADR_SMR, 8'h40);
    @(posedge clock);
    stop_mode <= 1'b1;
    stop_wake <= 8'h01;
    rst_len;
    stop_wake <= 8'h00;
    chk(n, amrp_pkg::HOLD_CYCLES);
    chk({wdtm_out, p2m_out, p3m_out}, 24'h5C3321);
    wb(0, amrp_pkg::ADR_RP, 8'h00);
    chk(q, 0);
    wb(0, amrp_pkg::ADR_SMR, 8'h00);
    chk(q, 32'h80);
    wdt_timeout <= 1'b1;
    rst_len;
    chk({wdtm_out, p2m_out, p3m_out}, 24'h000000);
  endtask
  // Mid-run power-up with ROMless strap: fetches go outside
  task automatic t_romless;
    reset <= 1'b1;
    romless <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rst_len;
    chk(n, POR + 1);
    core.fetch(1'b1, 16'h0100);
    chk({fetch_int, fetch_vec, fetch_user}, 3'b000);
    wb(0, amrp_pkg::ADR_STAT, 8'h00);
    chk(q, 32'h09);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    t_por_regs_map;
    t_protect;
    t_recover;
    t_romless;
    give_verdict;
  end
endmodule
`default_nettype wire
